// [core/pvaa_defines.vh]
// Constants for the phone voice alarm access sequencer
`ifndef PVAA_DEFINES_VH
`define PVAA_DEFINES_VH
`define PVAA_CLK_HZ 20000000
`define PVAA_SEC_CYCLES 32'h0131_2D00
`define PVAA_NOPW_SEC 8'h28
`define PVAA_REDIAL_SEC 8'h14
`define PVAA_ENTRY_SEC 8'h09
`define PVAA_MAX_WRONG 2'h2
`define PVAA_SEC_PROMPT 7'h00
`define PVAA_SEC_OK 7'h01
`define PVAA_SEC_WRONG 7'h02
`define PVAA_SEC_ALARM 7'h03
`define PVAA_KEY_STAR 4'hA
`define PVAA_KEY_HASH 4'hB
`define PVAA_PW_RESET 16'h0000
`endif

// [core/pvaa_sec_timer.v]
// Seconds timer: counts whole seconds since the last restart
`include "pvaa_defines.vh"
module pvaa_sec_timer (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Control
   input wire restart,
   // Status
   output reg [7:0] seconds_r
);
   parameter [31:0] SEC_CYCLES = `PVAA_SEC_CYCLES;
   reg [31:0] tick_r;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_r <= 32'h0000_0000;
         seconds_r <= 8'h00;
      end else if (restart) begin
         tick_r <= 32'h0000_0000;
         seconds_r <= 8'h00;
      end else if (tick_r == SEC_CYCLES - 32'h0000_0001) begin
         tick_r <= 32'h0000_0000;
         // Saturate so long waits never wrap
         if (seconds_r != 8'hFF) begin
            seconds_r <= seconds_r + 8'h01;
         end
      end else begin
         tick_r <= tick_r + 32'h0000_0001;
      end
   end
endmodule // pvaa_sec_timer

// [core/pvaa_call_seq.v]
// Call-control sequencer for the telephone and voice module
// Functional notes
// - Sections zero to three are system prompts
// - Section zero only on answered incoming call
// - Section one only after correct password
// - Section two on the first two password mismatches
// - Section three when outgoing call connects
// - Incoming: off-hook, prompt, await password
// - Incoming wrong: section two, then prompt again
// - Outgoing: alarm section with section three
// - Outgoing correct: section one, repeat alarm
// - Outgoing wrong: section two, repeat three+alarm
// - No answer or password in 40s: redial
// - Star stops playback; four digits within 9s on incoming calls, within 40s of connection on outgoing
// - Incoming entry timeout: replay prompt, need star; outgoing timeout hangs up
// - Third wrong password hangs up to idle
// - After lockout redial every 20s if alarm
// - Alarm voice replays every 20s while armed, only on ticks that find the sequencer idle
// - Redial continues until remote clears alarm
`include "pvaa_defines.vh"
module pvaa_call_seq (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Telephone line
   input wire ringIn,
   input wire answeredIn,
   input wire lineDropIn,
   input wire keyValidIn,
   input wire [3:0] keyCodeIn,
   output reg offHook_r,
   output reg dialStart_r,
   // Voice playback
   input wire playDone,
   output reg playStart_r,
   output reg playStop_r,
   output reg [6:0] playSection_r,
   // Controller side
   input wire alarmIn,
   input wire [6:0] alarmSection,
   input wire [15:0] password,
   output reg cmdValid_r,
   output reg [3:0] cmdCode_r,
   output reg alarmArmed_r,
   output reg [2:0] callState_r
);
   parameter [31:0] SEC_CYCLES = `PVAA_SEC_CYCLES;
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_DIAL = 3'd1;
   localparam [2:0] ST_PROMPT = 3'd2;
   localparam [2:0] ST_ENTRY = 3'd3;
   localparam [2:0] ST_CONTROL = 3'd4;
   localparam [2:0] ST_HANGUP = 3'd5;
   // Play plan: which section follows the current one
   localparam [1:0] PL_PROMPT = 2'd0;
   localparam [1:0] PL_ALARM_THEN_3 = 2'd1;
   localparam [1:0] PL_3_THEN_ALARM = 2'd2;
   localparam [1:0] PL_LOOP_ALARM = 2'd3;

   // Line and key-valid inputs pass three flops, the key code two; a line input is high while stages two and three are both high, key valid changes when they agree
   reg [2:0] ringSync_r, ansSync_r, dropSync_r, keySync_r;
   reg [3:0] codeA_r, codeB_r;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ringSync_r <= 3'b000;
         ansSync_r <= 3'b000;
         dropSync_r <= 3'b000;
         keySync_r <= 3'b000;
         codeA_r <= 4'h0;
         codeB_r <= 4'h0;
      end else begin
         ringSync_r <= {ringSync_r[1:0], ringIn};
         ansSync_r <= {ansSync_r[1:0], answeredIn};
         dropSync_r <= {dropSync_r[1:0], lineDropIn};
         keySync_r <= {keySync_r[1:0], keyValidIn};
         codeA_r <= keyCodeIn;
         codeB_r <= codeA_r;
      end
   end
   wire ring = ringSync_r[1] & ringSync_r[2];
   wire answered = ansSync_r[1] & ansSync_r[2];
   wire lineDrop = dropSync_r[1] & dropSync_r[2];
   reg keyLevel_r;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         keyLevel_r <= 1'b0;
      end else if (keySync_r[1] == keySync_r[2]) begin
         keyLevel_r <= keySync_r[2];
      end
   end
   wire keyAgree = (keySync_r[1] == keySync_r[2]);
   // Key code is held stable by the receiver while valid is high
   wire keyHit = keyAgree & keySync_r[2] & ~keyLevel_r;
   wire isStar = (codeB_r == `PVAA_KEY_STAR);
   wire isDigit = (codeB_r <= 4'h9);

   reg [2:0] state_r, state_nxt;
   reg outgoing_r;
   reg [1:0] plan_r;
   reg [1:0] wrong_r;
   reg starSeen_r;
   reg pwOk_r;
   reg [2:0] digitCnt_r;
   reg [15:0] entry_r;
   reg timerRestart;
   wire [7:0] seconds;

   pvaa_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) uTimer (
      .clk(clk),
      .resetn(resetn),
      .restart(timerRestart),
      .seconds_r(seconds)
   );

   // Separate alarm-voice repeat timer so it runs across calls
   reg [31:0] repTick_r;
   reg [7:0] repSec_r;
   wire repDue = (repSec_r == `PVAA_REDIAL_SEC);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         repTick_r <= 32'h0000_0000;
         repSec_r <= 8'h00;
      end else if (!alarmArmed_r || repDue) begin
         repTick_r <= 32'h0000_0000;
         repSec_r <= 8'h00;
      end else if (repTick_r == SEC_CYCLES - 32'h0000_0001) begin
         repTick_r <= 32'h0000_0000;
         repSec_r <= repSec_r + 8'h01;
      end else begin
         repTick_r <= repTick_r + 32'h0000_0001;
      end
   end

   wire fourth = (digitCnt_r == 3'd3) & isDigit;
   wire [15:0] fullEntry = {entry_r[11:0], codeB_r};
   wire match = (fullEntry == password);
   // System prompt slots can never be reused as the alarm message
   wire [6:0] alarmSlot = (alarmSection <= `PVAA_SEC_ALARM) ? `PVAA_SEC_ALARM + 7'h01 : alarmSection;

   always @* begin
      state_nxt = state_r;
      timerRestart = 1'b0;
      case (state_r)
         ST_IDLE: begin
            timerRestart = 1'b1;
            if (ring) begin
               state_nxt = ST_PROMPT;
            end else if (alarmArmed_r && repDue) begin
               state_nxt = ST_DIAL;
            end
         end
         ST_DIAL: begin
            if (answered) begin
               state_nxt = ST_PROMPT;
               timerRestart = 1'b1;
            end else if (seconds >= `PVAA_NOPW_SEC) begin
               state_nxt = ST_HANGUP;
            end
         end
         ST_PROMPT: begin
            if (lineDrop) begin
               state_nxt = ST_HANGUP;
            end else if (outgoing_r && seconds >= `PVAA_NOPW_SEC) begin
               state_nxt = ST_HANGUP;
            end else if (keyHit && isStar) begin
               state_nxt = ST_ENTRY;
               timerRestart = !outgoing_r;
            end
         end
         ST_ENTRY: begin
            if (lineDrop) begin
               state_nxt = ST_HANGUP;
            end else if (!outgoing_r && seconds >= `PVAA_ENTRY_SEC) begin
               state_nxt = ST_PROMPT;
            end else if (outgoing_r && seconds >= `PVAA_NOPW_SEC) begin
               state_nxt = ST_HANGUP;
            end else if (keyHit && isDigit && digitCnt_r == 3'd3) begin
               if (match) begin
                  state_nxt = ST_CONTROL;
               end else if (wrong_r == `PVAA_MAX_WRONG) begin
                  state_nxt = ST_HANGUP;
               end else begin
                  state_nxt = ST_PROMPT;
               end
            end
         end
         ST_CONTROL: begin
            if (lineDrop || (keyHit && codeB_r == `PVAA_KEY_HASH && !starSeen_r)) begin
               state_nxt = ST_HANGUP;
            end
         end
         ST_HANGUP: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Entry window timer: restart on star; outgoing keeps the 40 s window from connection
   reg [31:0] entTick_r;
   reg [7:0] entSec_r;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         outgoing_r <= 1'b0;
         plan_r <= PL_PROMPT;
         wrong_r <= 2'h0;
         starSeen_r <= 1'b0;
         pwOk_r <= 1'b0;
         digitCnt_r <= 3'd0;
         entry_r <= 16'h0000;
         offHook_r <= 1'b0;
         dialStart_r <= 1'b0;
         playStart_r <= 1'b0;
         playStop_r <= 1'b0;
         playSection_r <= `PVAA_SEC_PROMPT;
         cmdValid_r <= 1'b0;
         cmdCode_r <= 4'h0;
         alarmArmed_r <= 1'b0;
         callState_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
         callState_r <= state_nxt;
         dialStart_r <= 1'b0;
         playStart_r <= 1'b0;
         playStop_r <= 1'b0;
         cmdValid_r <= 1'b0;
         // Alarm arms on the program's request; only a remote control code disarms
         if (alarmIn && !alarmArmed_r) begin
            alarmArmed_r <= 1'b1;
         end
         // Section numbers 0..3 are never chosen for the alarm slot
         case (state_r)
            ST_IDLE: begin
               wrong_r <= 2'h0;
               pwOk_r <= 1'b0;
               starSeen_r <= 1'b0;
               if (ring) begin
                  offHook_r <= 1'b1;
                  outgoing_r <= 1'b0;
                  plan_r <= PL_PROMPT;
                  playSection_r <= `PVAA_SEC_PROMPT;
                  playStart_r <= 1'b1;
               end else if (alarmArmed_r && repDue) begin
                  offHook_r <= 1'b1;
                  outgoing_r <= 1'b1;
                  dialStart_r <= 1'b1;
                  // Alarm voice is also sounded locally each period
                  playSection_r <= alarmSlot;
                  playStart_r <= 1'b1;
               end
            end
            ST_DIAL: begin
               if (answered) begin
                  plan_r <= PL_ALARM_THEN_3;
                  playSection_r <= alarmSlot;
                  playStart_r <= 1'b1;
               end
            end
            ST_PROMPT, ST_CONTROL: begin
               if (keyHit && isStar) begin
                  playStop_r <= 1'b1;
                  starSeen_r <= 1'b1;
                  digitCnt_r <= 3'd0;
               end else if (playDone && (state_r == ST_PROMPT || outgoing_r)) begin
                  // Incoming control stays silent after section one
                  case (plan_r)
                     PL_PROMPT: playSection_r <= `PVAA_SEC_PROMPT;
                     PL_ALARM_THEN_3: begin
                        playSection_r <= `PVAA_SEC_ALARM;
                        plan_r <= PL_3_THEN_ALARM;
                     end
                     PL_3_THEN_ALARM: begin
                        playSection_r <= alarmSlot;
                        plan_r <= PL_ALARM_THEN_3;
                     end
                     default: playSection_r <= alarmSlot;
                  endcase
                  playStart_r <= 1'b1;
               end
               if (state_r == ST_CONTROL && keyHit && isDigit && starSeen_r) begin
                  cmdValid_r <= 1'b1;
                  cmdCode_r <= codeB_r;
                  starSeen_r <= 1'b0;
                  if (codeB_r == 4'h0 && alarmArmed_r) begin
                     alarmArmed_r <= alarmIn;
                  end
               end
               if (state_r == ST_CONTROL && keyHit && !isStar && !isDigit) begin
                  starSeen_r <= 1'b0;
               end
            end
            ST_ENTRY: begin
               starSeen_r <= 1'b0;
               // Outgoing calls keep only the 40 s window, so a wrong entry is never mistaken for a timeout
               if (state_nxt == ST_PROMPT && !outgoing_r && seconds >= `PVAA_ENTRY_SEC) begin
                  playSection_r <= `PVAA_SEC_PROMPT;
                  playStart_r <= 1'b1;
               end else if (keyHit && isDigit) begin
                  entry_r <= fullEntry;
                  digitCnt_r <= digitCnt_r + 3'd1;
                  if (fourth) begin
                     digitCnt_r <= 3'd0;
                     if (match) begin
                        pwOk_r <= 1'b1;
                        playSection_r <= `PVAA_SEC_OK;
                        plan_r <= outgoing_r ? PL_LOOP_ALARM : PL_PROMPT;
                        playStart_r <= 1'b1;
                     end else begin
                        wrong_r <= wrong_r + 2'h1;
                        playSection_r <= `PVAA_SEC_WRONG;
                        // Plan names what follows: section three if outgoing, else section zero
                        plan_r <= outgoing_r ? PL_ALARM_THEN_3 : PL_PROMPT;
                        playStart_r <= (wrong_r != `PVAA_MAX_WRONG);
                     end
                  end
               end
            end
            ST_HANGUP: begin
               offHook_r <= 1'b0;
               playStop_r <= 1'b1;
               pwOk_r <= 1'b0;
            end
            default: begin
               offHook_r <= 1'b0;
            end
         endcase
      end
   end
endmodule // pvaa_call_seq

// [testbench/pvaa_call_seq_asserts.sv]
// Port checks for the call sequencer
module pvaa_call_seq_asserts #(
   parameter [31:0] SEC_CYCLES = 32'h0131_2D00
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Sequencer outputs
   input wire offHook_r,
   input wire dialStart_r,
   input wire playStart_r,
   input wire playStop_r,
   input wire [6:0] playSection_r,
   input wire cmdValid_r,
   input wire alarmArmed_r,
   input wire [2:0] callState_r
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   chk_prompt_at_pickup: assert property (
      $rose(offHook_r) && callState_r == 3'h2 |-> playStart_r && playSection_r == 7'h00)
      else $error("no prompt at pickup");
   chk_prompt_needs_line: assert property (
      playStart_r && playSection_r == 7'h00 |-> offHook_r) else $error("prompt while on hook");
   chk_ok_only_control: assert property (
      playStart_r && playSection_r == 7'h01 |-> callState_r == 3'h4) else $error("ok prompt early");
   chk_wrong_then_prompt: assert property (
      playStart_r && playSection_r == 7'h02 |-> callState_r inside {3'h2, 3'h5}) else $error("wrong state");
   chk_stop_on_star: assert property (
      callState_r == 3'h3 && $past(callState_r) == 3'h2 |-> playStop_r) else $error("no stop on star");
   chk_stop_one_cycle: assert property (
      playStop_r |=> !playStop_r) else $error("stop too long");
   chk_cmd_in_control: assert property (
      cmdValid_r |-> callState_r == 3'h4) else $error("command outside control");
   chk_dial_when_armed: assert property (
      dialStart_r |-> alarmArmed_r) else $error("dial while disarmed");
endmodule // pvaa_call_seq_asserts
bind pvaa_call_seq pvaa_call_seq_asserts #(.SEC_CYCLES(SEC_CYCLES)) pvaa_call_seq_asserts_inst (
   .clk(clk), .resetn(resetn), .offHook_r(offHook_r), .dialStart_r(dialStart_r), .playStart_r(playStart_r),
   .playStop_r(playStop_r), .playSection_r(playSection_r), .cmdValid_r(cmdValid_r),
   .alarmArmed_r(alarmArmed_r), .callState_r(callState_r));

// [testbench/pvaa_caller_model.sv]
// Remote caller: rings, answers, hangs up, keys tones
module pvaa_caller_model (
   // Clock
   input wire clk,
   // Line toward the sequencer
   output logic ringIn,
   output logic answeredIn,
   output logic lineDropIn,
   output logic keyValidIn,
   output logic [3:0] keyCodeIn
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ringIn = 1'h0;
      answeredIn = 1'h0;
      lineDropIn = 1'h0;
      keyValidIn = 1'h0;
      keyCodeIn = 4'h0;
   end
   // Held long enough to pass the input synchronisers
   task automatic press(input logic [3:0] code);
      @(posedge clk);
      keyValidIn <= 1'h1;
      keyCodeIn <= code;
      repeat (6) @(posedge clk);
      keyValidIn <= 1'h0;
      keyCodeIn <= ~code; // Undriven tone bus must not look like the old key
      repeat (6) @(posedge clk);
   endtask
   task automatic enter(input logic [15:0] pin);
      press(4'hA);
      for (int i = 3; i >= 0; i--) begin
         press(pin[i*4 +: 4]);
      end
   endtask
   task automatic ring();
      @(posedge clk);
      ringIn <= 1'h1;
      repeat (8) @(posedge clk);
      ringIn <= 1'h0;
   endtask
   task automatic drop();
      @(posedge clk);
      lineDropIn <= 1'h1;
      repeat (8) @(posedge clk);
      lineDropIn <= 1'h0;
   endtask
   task automatic answer(input logic level);
      @(posedge clk);
      answeredIn <= level;
   endtask
endmodule // pvaa_caller_model

// [testbench/pvaa_call_seq_bench.sv]
// Self-checking bench for the call sequencer
`include "pvaa_defines.vh"
module pvaa_call_seq_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // One second is 20 cycles, so 9 s = 180, 20 s = 400, 40 s = 800
   localparam [31:0] SEC = 32'h0000_0014;
   localparam [15:0] PIN = 16'h1234;
   logic clk, resetn, playDone, alarmIn, ringIn, answeredIn, lineDropIn, keyValidIn;
   logic offHook_r, playStart_r, playStop_r, cmdValid_r, alarmArmed_r, stopSeen, cmdSeen, dialStart_r, dialSeen;
   logic [3:0] keyCodeIn, cmdCode_r, lastCmd;
   logic [6:0] playSection_r, alarmSec;
   logic [15:0] pinCode;
   logic [2:0] callState_r;
   logic [127:0] heard;
   int num_errors, compares, cycles;
   pvaa_call_seq #(.SEC_CYCLES(SEC)) pvaa_call_seq_inst (
      .clk(clk), .resetn(resetn), .ringIn(ringIn), .answeredIn(answeredIn), .lineDropIn(lineDropIn),
      .keyValidIn(keyValidIn), .keyCodeIn(keyCodeIn), .offHook_r(offHook_r), .dialStart_r(dialStart_r),
      .playDone(playDone), .playStart_r(playStart_r), .playStop_r(playStop_r), .playSection_r(playSection_r),
      .alarmIn(alarmIn), .alarmSection(alarmSec), .password(pinCode), .cmdValid_r(cmdValid_r),
      .cmdCode_r(cmdCode_r), .alarmArmed_r(alarmArmed_r), .callState_r(callState_r));
   pvaa_caller_model pvaa_caller_model_inst (
      .clk(clk), .ringIn(ringIn), .answeredIn(answeredIn), .lineDropIn(lineDropIn),
      .keyValidIn(keyValidIn), .keyCodeIn(keyCodeIn));
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // Pulses land while the caller is still keying, so latch them
   always @(negedge clk) begin
      if (playStart_r === 1'h1) heard[playSection_r] <= 1'h1;
      if (playStop_r === 1'h1) stopSeen <= 1'h1;
      if (dialStart_r === 1'h1) dialSeen <= 1'h1;
      if (cmdValid_r === 1'h1) begin
         cmdSeen <= 1'h1;
         lastCmd <= cmdCode_r;
      end
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hear(input logic [6:0] sec, input int limit);
      int n;
      n = 0;
      while (heard[sec] !== 1'h1 && n < limit) begin
         @(negedge clk);
         n++;
      end
      check("section heard", {9'h000, sec}, heard[sec] === 1'h1 ? {9'h000, sec} : 16'hFFFF);
      heard = '0;
   endtask
   task automatic awaitState(input logic [2:0] exp, input int limit);
      int n;
      n = 0;
      while (callState_r !== exp && n < limit) begin
         @(negedge clk);
         n++;
      end
      check("callState", {13'h0000, exp}, {13'h0000, callState_r});
   endtask
   task automatic finishPlay();
      repeat (8) @(posedge clk);
      playDone <= 1'h1;
      @(posedge clk);
      playDone <= 1'h0;
   endtask
   task automatic incomingGood();
      pvaa_caller_model_inst.ring();
      hear(`PVAA_SEC_PROMPT, 20);
      stopSeen = 1'h0;
      pvaa_caller_model_inst.enter(PIN);
      check("stop", 16'h0001, {15'h0000, stopSeen});
      hear(`PVAA_SEC_OK, 10);
      awaitState(3'h4, 5);
      heard = '0;
      finishPlay();
      repeat (2) @(negedge clk);
      check("control replay", 16'h0000, {9'h000, heard[6:0]});
      cmdSeen = 1'h0;
      pvaa_caller_model_inst.press(4'h6);
      pvaa_caller_model_inst.press(`PVAA_KEY_STAR);
      pvaa_caller_model_inst.press(4'h5);
      check("command", 16'h0015, {11'h000, cmdSeen, lastCmd});
      pvaa_caller_model_inst.press(`PVAA_KEY_HASH);
      awaitState(3'h0, 20);
   endtask
   task automatic incomingWrong();
      pvaa_caller_model_inst.ring();
      hear(`PVAA_SEC_PROMPT, 20);
      for (int i = 0; i < 3; i++) begin
         pvaa_caller_model_inst.enter(16'h9999);
         if (i < 2) begin
            hear(`PVAA_SEC_WRONG, 10);
            finishPlay();
            hear(`PVAA_SEC_PROMPT, 10);
         end
      end
      awaitState(3'h0, 40);
      check("offHook", 16'h0000, {15'h0000, offHook_r});
   endtask
   task automatic entryTimeout();
      pvaa_caller_model_inst.ring();
      hear(`PVAA_SEC_PROMPT, 20);
      pvaa_caller_model_inst.press(4'h1);
      awaitState(3'h2, 1);
      pvaa_caller_model_inst.press(`PVAA_KEY_STAR);
      awaitState(3'h3, 1);
      hear(`PVAA_SEC_PROMPT, 200);
      awaitState(3'h2, 5);
      pvaa_caller_model_inst.drop();
      awaitState(3'h0, 30);
   endtask
   task automatic alarmCall();
      @(posedge clk);
      alarmIn <= 1'h1;
      dialSeen = 1'h0;
      awaitState(3'h1, 450);
      // Let the local alarm play latch before clearing
      @(negedge clk);
      check("dial", 16'h0001, {15'h0000, dialSeen});
      heard = '0;
      pvaa_caller_model_inst.answer(1'h1);
      repeat (3) finishPlay();
      check("alarm pair", 16'h0003, {14'h0000, heard[`PVAA_SEC_ALARM], heard[4]});
      awaitState(3'h0, 900);
      pvaa_caller_model_inst.answer(1'h0);
      awaitState(3'h1, 450);
      @(posedge clk);
      alarmSec <= 7'h05;
      pinCode <= 16'h4071;
      pvaa_caller_model_inst.answer(1'h1);
      heard = '0;
      finishPlay();
      hear(`PVAA_SEC_ALARM, 20);
      pvaa_caller_model_inst.enter(PIN);
      hear(`PVAA_SEC_WRONG, 10);
      finishPlay();
      hear(`PVAA_SEC_ALARM, 10);
      finishPlay();
      hear(7'h05, 10);
      pvaa_caller_model_inst.enter(16'h4071);
      hear(`PVAA_SEC_OK, 10);
      finishPlay();
      hear(7'h05, 20);
      @(posedge clk);
      alarmIn <= 1'h0;
      pvaa_caller_model_inst.press(`PVAA_KEY_STAR);
      pvaa_caller_model_inst.press(4'h0);
      check("armed", 16'h0000, {15'h0000, alarmArmed_r});
      pvaa_caller_model_inst.press(`PVAA_KEY_HASH);
      awaitState(3'h0, 20);
      pvaa_caller_model_inst.answer(1'h0);
      // A disarmed alarm must not dial again
      dialSeen = 1'h0;
      repeat (450) @(posedge clk);
      check("redial after clear", 16'h0000, {15'h0000, dialSeen});
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      resetn = 1'h0;
      playDone = 1'h0;
      alarmIn = 1'h0;
      heard = '0;
      alarmSec = 7'h04;
      pinCode = PIN;
      dialSeen = 1'h0;
      num_errors = 0;
      compares = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'h1;
      repeat (4) @(posedge clk);
      incomingGood();
      incomingWrong();
      entryTimeout();
      alarmCall();
      wrap_up();
   end
endmodule // pvaa_call_seq_bench
